// [rtl/cso_ctrl.sv]
// Sense oscillator control block with AXI4-Lite register slave
//
// What this block does
// - Oscillator keeps running in sleep while enabled
// - Timer1 may count oscillator during sleep
// - Timer0 never counts during sleep
// - Main bit 7 enables the module
// - Main bit 6 selects high or low range
// - Low range current 00 means oscillator off
// - High range 00 means noise detect, running
// - Main bit 1 reads oscillator direction
// - Bit 0 picks oscillator or clock pin
// - Internal select counts instruction clock, divide four
// - Disabled module connects no channel
// - Codes 0 to 11 pick channels
// - Unimplemented bits ignore writes, read zero
// - Implemented bits reset to zero
// - Timer1 source 11 uses the oscillator
`timescale 1ns/100ps
`include "cso_params.svh"

module cso_ctrl #(
    parameter int ADDR_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Part state and analog side
    input wire logic sleep_active,
    input wire logic osc_direction_raw,
    input wire logic osc_edge,
    input wire logic timer0_clock_pin,
    input wire logic timer1_other_tick,
    output cso_pkg::cso_analog_t analog_ctrl,
    output cso_pkg::cso_timer_t timer_route
);

    // Address must at least reach the highest register
    // Wider than one word would not fit the word compare below
    if (ADDR_W < 4 || ADDR_W > 32) begin
        $error("ADDR_W must lie between 4 and 32");
    end

    // Control registers hold only implemented bits; others stay zero
    logic [7:0] main_q;
    logic [7:0] chan_q;
    logic [7:0] timer_q;

    // Direction synchroniser, first stage read only by the second
    logic dir_meta_q;
    logic dir_sync_q;

    // Divide-by-four enable for the instruction clock
    logic [1:0] div_q;
    logic instr_tick;

    // Pending write halves and handshake state
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Word address compare shared by read and write decode
    // Low two address bits are ignored; each register is one aligned word
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] off);
        hit = ({{(32 - ADDR_W){1'b0}}, a[ADDR_W-1:2], 2'b00} == off);
    endfunction

    // Merge one byte of write data under its strobe and mask
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                         input logic en, input logic [7:0] mask);
        merge = en ? (nw & mask) : old;
    endfunction

    // Handshake outputs: each write channel is ready while its half is not held
    // Readies drop while a response waits, so a new write never overtakes it
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Current halves, taken this edge or held from earlier
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_fire;
    logic wr_mapped;
    assign aw_have = aw_held_q || (s_axi_awvalid && s_axi_awready);
    assign w_have = w_held_q || (s_axi_wvalid && s_axi_wready);
    assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_fire = aw_have && w_have && !bvalid_q;
    assign wr_mapped = hit(wr_addr, `CSO_OFF_MAIN) || hit(wr_addr, `CSO_OFF_CHAN)
                       || hit(wr_addr, `CSO_OFF_TIMER) || hit(wr_addr, `CSO_OFF_STATUS);
    logic wr_strb0;
    assign wr_strb0 = w_held_q ? w_strb_q[0] : s_axi_wstrb[0];

    // Hold whichever write half arrives first until the other comes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response one edge after both halves are present
    // A master that stalls bready blocks further writes until it answers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `CSO_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            // Unmapped addresses answer with a slave error and change nothing
            bresp_q <= wr_mapped ? `CSO_RESP_OKAY : `CSO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Main control register; status and unimplemented bits never stored
    // A write to the direction bit is lost; the bit is rebuilt on every read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_q <= `CSO_MAIN_RESET;
        end else if (wr_fire && hit(wr_addr, `CSO_OFF_MAIN)) begin
            main_q <= merge(main_q, wr_data[7:0], wr_strb0, `CSO_MAIN_WMASK);
        end
    end

    // Channel register; upper nibble is unimplemented
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_q <= `CSO_CHAN_RESET;
        end else if (wr_fire && hit(wr_addr, `CSO_OFF_CHAN)) begin
            // Reserved codes are stored as written; decode refuses them
            chan_q <= merge(chan_q, wr_data[7:0], wr_strb0, `CSO_CHAN_WMASK);
        end
    end

    // Timer routing register mirrors the timer selects this block needs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_q <= `CSO_TIMER_RESET;
        end else if (wr_fire && hit(wr_addr, `CSO_OFF_TIMER)) begin
            timer_q <= merge(timer_q, wr_data[7:0], wr_strb0, `CSO_TIMER_WMASK);
        end
    end

    // Two-flop synchroniser for the analog direction level
    // The first stage may go metastable, so only the second stage is read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_meta_q <= 1'b0;
            dir_sync_q <= 1'b0;
        end else begin
            dir_meta_q <= osc_direction_raw;
            dir_sync_q <= dir_meta_q;
        end
    end

    // Instruction clock enable: one pulse every four system clocks
    // Free running from reset, so its phase is not tied to register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign instr_tick = (div_q == 2'(`CSO_INSTR_DIV - 1));

    // Field views of the control registers
    logic enable;
    logic high_range;
    logic [1:0] level;
    logic t0_ext_osc;
    logic t0_ext_clock;
    logic t1_from_osc;
    logic [7:0] main_view;
    assign enable = main_q[`CSO_BIT_ENABLE];
    assign high_range = main_q[`CSO_BIT_RANGE];
    assign level = main_q[`CSO_LVL_HI:`CSO_LVL_LO];
    assign t0_ext_osc = main_q[`CSO_BIT_T0XS];
    assign t0_ext_clock = timer_q[`CSO_TBIT_T0CS];
    assign t1_from_osc = (timer_q[`CSO_TBIT_T1SRC_HI:`CSO_TBIT_T1SRC_LO] == `CSO_T1SRC_OSC);

    // Main register as read: synchronised direction in bit 1
    always_comb begin
        main_view = main_q;
        main_view[`CSO_BIT_DIR] = dir_sync_q;
    end

    // Read data registered one edge after the address is taken
    // Reads have no side effects, so a repeated read is harmless
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `CSO_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= `CSO_RESP_OKAY;
            if (hit(s_axi_araddr, `CSO_OFF_MAIN)) begin
                rdata_q <= {24'h00_0000, main_view};
            end else if (hit(s_axi_araddr, `CSO_OFF_CHAN)) begin
                rdata_q <= {24'h00_0000, chan_q};
            end else if (hit(s_axi_araddr, `CSO_OFF_TIMER)) begin
                rdata_q <= {24'h00_0000, timer_q};
            end else if (hit(s_axi_araddr, `CSO_OFF_STATUS)) begin
                // Live state: decoded drive, channel connected, sleep seen
                rdata_q <= {24'h00_0000, analog_ctrl.chan_valid, analog_ctrl.osc_run,
                            3'(analog_ctrl.drive), 1'b0, 1'b0, sleep_active};
            end else begin
                // Unmapped: zero data with a slave error
                rdata_q <= 32'h0000_0000;
                rresp_q <= `CSO_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Drive decode; sleep is deliberately absent so the oscillator keeps running
    // Registered below, so the drive follows a write one cycle later
    cso_pkg::cso_drive_t drive_d;
    logic run_d;
    always_comb begin
        drive_d = cso_pkg::CSO_DRV_OFF;
        run_d = 1'b0;
        if (enable) begin
            case (level)
                2'h0: begin
                    // Noise detection keeps the oscillator alive in high range
                    drive_d = high_range ? cso_pkg::CSO_DRV_NOISE : cso_pkg::CSO_DRV_OFF;
                    run_d = high_range;
                end
                2'h1: begin
                    drive_d = cso_pkg::CSO_DRV_LOW;
                    run_d = 1'b1;
                end
                2'h2: begin
                    drive_d = cso_pkg::CSO_DRV_MED;
                    run_d = 1'b1;
                end
                2'h3: begin
                    drive_d = cso_pkg::CSO_DRV_HIGH;
                    run_d = 1'b1;
                end
                default: begin
                    drive_d = cso_pkg::CSO_DRV_OFF;
                    run_d = 1'b0;
                end
            endcase
        end
    end

    // Analog control outputs from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.osc_run <= run_d;
            analog_ctrl.high_range <= high_range;
            analog_ctrl.drive <= drive_d;
            // Reserved codes and a disabled module connect nothing
            analog_ctrl.chan_valid <= enable && (chan_q[3:0] <= `CSO_LAST_CHANNEL);
            analog_ctrl.chan_index <= enable ? chan_q[3:0] : 4'h0;
        end
    end

    // Timer clock routing as one-cycle tick enables
    // Ticks lag their sources by one cycle; counts over a window are unaffected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_route <= '0;
        end else begin
            timer_route.timer0_from_osc <= t0_ext_clock && t0_ext_osc;
            timer_route.timer1_from_osc <= t1_from_osc;
            if (sleep_active) begin
                // The core timer halts in sleep, so it cannot measure there
                timer_route.timer0_tick <= 1'b0;
            end else if (!t0_ext_clock) begin
                timer_route.timer0_tick <= instr_tick;
            end else begin
                timer_route.timer0_tick <= t0_ext_osc ? osc_edge : timer0_clock_pin;
            end
            // Timer1 keeps gathering counts through sleep
            timer_route.timer1_tick <= t1_from_osc ? osc_edge : timer1_other_tick;
        end
    end

endmodule

// [inc/cso_params.svh]
// Register offsets, field positions, reset values and decode constants for the sense control block
`ifndef CSO_PARAMS_SVH
`define CSO_PARAMS_SVH
`define CSO_OFF_MAIN 32'h0000_0000
`define CSO_OFF_CHAN 32'h0000_0004
`define CSO_OFF_TIMER 32'h0000_0008
`define CSO_OFF_STATUS 32'h0000_000C
`define CSO_MAIN_RESET 8'h00
`define CSO_CHAN_RESET 8'h00
`define CSO_TIMER_RESET 8'h00
`define CSO_MAIN_WMASK 8'hCD
`define CSO_CHAN_WMASK 8'h0F
`define CSO_TIMER_WMASK 8'h07
`define CSO_BIT_ENABLE 7
`define CSO_BIT_RANGE 6
`define CSO_LVL_HI 3
`define CSO_LVL_LO 2
`define CSO_BIT_DIR 1
`define CSO_BIT_T0XS 0
`define CSO_TBIT_T0CS 0
`define CSO_TBIT_T1SRC_HI 2
`define CSO_TBIT_T1SRC_LO 1
`define CSO_T1SRC_OSC 2'h3
`define CSO_LAST_CHANNEL 4'hB
`define CSO_NUM_CHANNELS 12
`define CSO_INSTR_DIV 4
`define CSO_RESP_OKAY 2'h0
`define CSO_RESP_SLVERR 2'h2
`endif

// [inc/cso_pkg.sv]
// Types shared by the sense oscillator control block
package cso_pkg;
    // Oscillator drive strength decoded from range and current field
    typedef enum logic [2:0] {
        CSO_DRV_OFF,
        CSO_DRV_NOISE,
        CSO_DRV_LOW,
        CSO_DRV_MED,
        CSO_DRV_HIGH
    } cso_drive_t;

    // Analog control bundle toward the oscillator
    typedef struct packed {
        logic osc_run;
        logic high_range;
        cso_drive_t drive;
        logic chan_valid;
        logic [3:0] chan_index;
    } cso_analog_t;

    // Clock routing bundle toward the timers
    typedef struct packed {
        logic timer0_tick;
        logic timer1_tick;
        logic timer0_from_osc;
        logic timer1_from_osc;
    } cso_timer_t;
endpackage

// [tb/cso_ctrl_chk.sv]
// Assertion checker for the sense oscillator control block
`timescale 1ns/100ps
module cso_ctrl_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_active,
    input wire logic osc_edge,
    input wire cso_pkg::cso_analog_t analog_ctrl,
    input wire cso_pkg::cso_timer_t timer_route
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Responses stand until the master takes them
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // Both halves taken together give a response next cycle
    AST_B_SOON: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write response late");
    AST_RESET: assert property ($rose(aresetn) |-> analog_ctrl == '0 && timer_route == '0)
        else $error("outputs not cleared by reset");
    AST_T0_SLEEP: assert property (sleep_active |=> !timer_route.timer0_tick)
        else $error("timer0 ticked in sleep");
    AST_T1_OSC: assert property (timer_route.timer1_from_osc && $past(timer_route.timer1_from_osc)
        |-> timer_route.timer1_tick == $past(osc_edge)) else $error("timer1 not fed by oscillator");
    AST_CHAN: assert property (analog_ctrl.chan_valid |-> analog_ctrl.chan_index <= 4'hB)
        else $error("reserved channel connected");
    AST_OFF: assert property (analog_ctrl.drive == cso_pkg::CSO_DRV_OFF |-> !analog_ctrl.osc_run)
        else $error("oscillator runs while off");
    AST_NOISE: assert property (analog_ctrl.drive == cso_pkg::CSO_DRV_NOISE
        |-> analog_ctrl.high_range && analog_ctrl.osc_run) else $error("noise mode wrong");
    // Main scenarios reached
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (timer_route.timer1_from_osc && timer_route.timer1_tick && sleep_active);
endmodule

// [tb/cso_osc_model.sv]
// Behavioural model of the oscillator, clock pin and other Timer1 source
`timescale 1ns/100ps
module cso_osc_model #(
    parameter int P_OSC = 3,
    parameter int P_PIN = 5,
    parameter int P_OTH = 7
) (
    input wire logic aclk,
    input wire logic dir_in,
    output logic osc_direction_raw,
    output logic osc_edge,
    output logic timer0_clock_pin,
    output logic timer1_other_tick
);
    int n = 0; // Free running cycle count
    // Pulses keep coming in sleep; distinct periods expose a wrong source pick
    always @(posedge aclk) begin
        n <= n + 1;
        osc_edge <= (n % P_OSC) == 0;
        timer0_clock_pin <= (n % P_PIN) == 0;
        timer1_other_tick <= (n % P_OTH) == 0;
    end
    // Direction moves off the clock grid, so the design must synchronise it
    assign #3 osc_direction_raw = dir_in;
endmodule

// [tb/cso_ctrl_bench.sv]
// Self-checking bench for the sense oscillator control block
`timescale 1ns/100ps
module cso_ctrl_bench;
    logic aclk = 0;
    logic aresetn = 0;
    logic [4:0] awaddr = '0; // One address bit more than needed reaches unmapped space
    logic [4:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, sleep = 0, dir = 0;
    logic awready, wready, bvalid, arready, rvalid, odir, oedge, pin, oth;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    cso_pkg::cso_analog_t ana;
    cso_pkg::cso_timer_t trt;
    logic [33:0] bq[$], rq[$]; // Expected responses, oldest first
    int err_total = 0, n_tests = 0, cyc = 0, seed = 32'h61F3;
    int c0, c1, ce, cp, co; // Pulse counts in a window
    logic cnt_on = 0, e_d = 0, p_d = 0, o_d = 0;
    always #4 aclk = ~aclk;
    cso_ctrl #(.ADDR_W(5)) u_cso_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_active(sleep), .osc_direction_raw(odir), .osc_edge(oedge),
        .timer0_clock_pin(pin), .timer1_other_tick(oth), .analog_ctrl(ana), .timer_route(trt));
    cso_osc_model u_cso_osc_model (.aclk(aclk), .dir_in(dir), .osc_direction_raw(odir),
        .osc_edge(oedge), .timer0_clock_pin(pin), .timer1_other_tick(oth));
    task cmp(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write: ready is sampled mid-cycle, where it stays until the next edge
    task wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
        logic sa, sw, sb;
        bq.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= {24'($random(seed)), d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            sa = awready;
            sw = wready;
            sb = bvalid;
            @(posedge aclk);
            if (sa) awvalid <= 1'b0;
            if (sw) wvalid <= 1'b0;
        end while (!sb);
        bready <= 1'b0;
        @(posedge aclk); // Next call raises bready only after this edge
    endtask
    task rd(input logic [4:0] a, input logic [33:0] e);
        logic sa, sr;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            sa = arready;
            sr = rvalid;
            @(posedge aclk);
            if (sa) arvalid <= 1'b0;
        end while (!sr);
        rready <= 1'b0;
        @(posedge aclk); // Next call raises rready only after this edge
    endtask
    // Routing window: set timers, main and sleep, then count 40 cycles
    task tmeas(input logic [7:0] tm, input logic [7:0] mn, input logic s);
        wr(5'h08, tm, 2'h0);
        wr(5'h00, mn, 2'h0);
        sleep <= s;
        repeat (3) @(posedge aclk);
        {c0, c1, ce, cp, co} = '0;
        cnt_on <= 1'b1;
        repeat (40) @(posedge aclk);
        cnt_on <= 1'b0;
    endtask
    // Watcher: each response taken is checked against the oldest note
    always @(negedge aclk) begin
        if (bvalid && bready) cmp({bresp, 32'h0}, bq.pop_front());
        if (rvalid && rready) cmp({rresp, rdata}, rq.pop_front());
        if (cnt_on) begin
            c0 += trt.timer0_tick;
            c1 += trt.timer1_tick;
            ce += e_d;
            cp += p_d;
            co += o_d;
        end
        // Sources seen one cycle earlier line up with the delayed ticks
        e_d = oedge;
        p_d = pin;
        o_d = oth;
    end
    task results();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end
    initial begin
        logic [2:0] dv;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(5'h00, 34'h0);
        rd(5'h04, 34'h0);
        rd(5'h10, {2'h2, 32'h0});
        wr(5'h10, 8'hFF, 2'h2);
        wr(5'h00, 8'hFF, 2'h0);
        rd(5'h00, 34'hCD);
        wr(5'h04, 8'hFB, 2'h0);
        rd(5'h04, 34'h0B);
        cmp(34'({ana.chan_valid, ana.chan_index}), 34'h1B);
        dir <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(5'h00, 34'hCF);
        for (int i = 0; i < 8; i++) begin
            wr(5'h00, {1'b1, i[2], 2'b00, i[1:0], 2'b00}, 2'h0);
            dv = (i[1:0] == 2'b00) ? {2'b00, i[2]} : 3'(i[1:0] + 1);
            cmp(34'({ana.osc_run, ana.high_range, ana.drive}), 34'({dv != 3'h0, i[2], dv}));
        end
        for (int k = 0; k < 12; k++) begin
            wr(5'h04, {4'($random(seed)), 4'(k)}, 2'h0);
            cmp(34'({ana.chan_valid, ana.chan_index}), 34'({1'b1, 4'(k)}));
        end
        wr(5'h00, 8'h00, 2'h0);
        cmp(34'({ana.chan_valid, ana.chan_index, ana.osc_run}), 34'h0);
        tmeas(8'h00, 8'h80, 1'b0);
        cmp(34'(c0), 34'd10);
        cmp(34'({trt.timer0_from_osc, trt.timer1_from_osc}), 34'h0);
        cmp(34'(c1), 34'(co));
        tmeas(8'h01, 8'h81, 1'b0);
        cmp(34'(c0), 34'(ce));
        tmeas(8'h01, 8'h80, 1'b0);
        cmp(34'(c0), 34'(cp));
        tmeas(8'h07, 8'hC1, 1'b1);
        cmp(34'(c0), 34'h0);
        cmp(34'(c1), 34'(ce));
        cmp(34'(ana.osc_run), 34'h1);
        cmp(34'({trt.timer0_from_osc, trt.timer1_from_osc}), 34'h3);
        rd(5'h0C, 34'hC9);
        sleep <= 1'b0;
        dir <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(5'h00, 34'h0);
        rd(5'h04, 34'h0);
        rd(5'h08, 34'h0);
        results();
    end
endmodule
bind cso_ctrl cso_ctrl_chk u_cso_ctrl_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep_active(sleep_active), .osc_edge(osc_edge),
    .analog_ctrl(analog_ctrl), .timer_route(timer_route));
